// ### rtl/csdec_pkg.sv
// Purpose: Shared constants and types for the condition and system-register field decoder
// Assumes: Condition field is four bits, selector field is three bits
// Notes: Field positions, codes and reset values live here only
package csdec_pkg;

	// ----------------------------------------------------------------
	// Condition field layout
	// ----------------------------------------------------------------
	localparam int COND_W = 4;            // Width of the conditional-test field
	localparam int INV_BIT = 0;           // Invert bit position
	localparam int SEL_LSB = 1;           // Condition selector low bit
	localparam int SEL_MSB = 3;           // Condition selector high bit

	// ----------------------------------------------------------------
	// Condition selector codes (three-bit)
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CSDEC_C_OVERFLOW = 3'h0,        // Overflow
		CSDEC_C_BELOW = 3'h1,           // Unsigned below
		CSDEC_C_ZERO = 3'h2,            // Equal or zero
		CSDEC_C_BELOW_EQ = 3'h3,        // Unsigned below or equal
		CSDEC_C_SIGN = 3'h4,            // Sign
		CSDEC_C_PARITY = 3'h5,          // Parity even
		CSDEC_C_LESS = 3'h6,            // Signed less
		CSDEC_C_LESS_EQ = 3'h7          // Signed less or equal
	} csdec_cond_t;

	// ----------------------------------------------------------------
	// System register class
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CSDEC_CLS_CTRL = 2'h0,          // Control registers
		CSDEC_CLS_DEBUG = 2'h1,         // Debug registers
		CSDEC_CLS_TEST = 2'h2,          // Test registers
		CSDEC_CLS_NONE = 2'h3           // Not a system-register move
	} csdec_cls_t;

	// ----------------------------------------------------------------
	// Selector codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SR_CODE_0 = 3'h0;  // Register zero
	localparam logic [2:0] SR_CODE_1 = 3'h1;  // Register one
	localparam logic [2:0] SR_CODE_2 = 3'h2;  // Register two
	localparam logic [2:0] SR_CODE_3 = 3'h3;  // Register three
	localparam logic [2:0] SR_CODE_6 = 3'h6;  // Register six
	localparam logic [2:0] SR_CODE_7 = 3'h7;  // Register seven

	// ----------------------------------------------------------------
	// One-hot select vector bit positions
	// ----------------------------------------------------------------
	localparam int SEL_N = 11;                // Number of selectable registers
	localparam int B_CTRL0 = 0;               // control_reg_zero
	localparam int B_CTRL2 = 1;               // control_reg_two
	localparam int B_CTRL3 = 2;               // control_reg_three
	localparam int B_DBG0 = 3;                // debug_reg_zero
	localparam int B_DBG1 = 4;                // debug_reg_one
	localparam int B_DBG2 = 5;                // debug_reg_two
	localparam int B_DBG3 = 6;                // debug_reg_three
	localparam int B_DBG6 = 7;                // debug_reg_six
	localparam int B_DBG7 = 8;                // debug_reg_seven
	localparam int B_TST6 = 9;                // test_reg_six
	localparam int B_TST7 = 10;               // test_reg_seven

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [10:0] RST_SEL = 11'h000;  // No register selected
	localparam logic RST_BIT = 1'b0;            // Flags clear after reset

endpackage : csdec_pkg

// ### rtl/csdec_cond_eval.sv
// Purpose: Pure combinational evaluation of one condition selector against the flags
// Assumes: Flags come from the same clock domain, already stable
// Notes: Negation is applied by the caller, not here
module csdec_cond_eval
(
	input wire logic [2:0] sel,        // Three-bit condition selector
	input wire logic flag_cf,          // Carry flag
	input wire logic flag_zf,          // Zero flag
	input wire logic flag_sf,          // Sign flag
	input wire logic flag_of,          // Overflow flag
	input wire logic flag_pf,          // Parity flag
	output logic hit                   // Selected condition before inversion
);

	// ----------------------------------------------------------------
	// Selector to raw condition
	// ----------------------------------------------------------------
	always_comb
	begin
		unique case (csdec_pkg::csdec_cond_t'(sel))
			csdec_pkg::CSDEC_C_OVERFLOW: hit = flag_of;
			csdec_pkg::CSDEC_C_BELOW: hit = flag_cf;
			csdec_pkg::CSDEC_C_ZERO: hit = flag_zf;
			csdec_pkg::CSDEC_C_BELOW_EQ: hit = flag_cf | flag_zf;
			csdec_pkg::CSDEC_C_SIGN: hit = flag_sf;
			csdec_pkg::CSDEC_C_PARITY: hit = flag_pf;
			csdec_pkg::CSDEC_C_LESS: hit = flag_sf ^ flag_of;
			csdec_pkg::CSDEC_C_LESS_EQ: hit = (flag_sf ^ flag_of) | flag_zf;
		endcase
	end

endmodule : csdec_cond_eval

// ### rtl/csdec_top.sv
// Purpose: Decode the conditional-test and system-register selector fields
// Assumes: Opcode fields and flags arrive from core logic on the same clock
// Notes: All outputs registered; one cycle from input to output
module csdec_top
(
	input wire logic clk,                 // Core clock, 40 MHz
	input wire logic nrst,                // Asynchronous reset, active low
	input wire logic ce,                  // Clock enable, freezes state when low
	input wire logic cond_valid,          // Condition field is present this cycle
	input wire logic [3:0] cond_field,    // Conditional-test field
	input wire logic flag_cf,             // Carry flag
	input wire logic flag_zf,             // Zero flag
	input wire logic flag_sf,             // Sign flag
	input wire logic flag_of,             // Overflow flag
	input wire logic flag_pf,             // Parity flag
	input wire logic sr_valid,            // Selector field is present this cycle
	input wire logic [1:0] sr_class,      // Register class of the move
	input wire logic [2:0] sr_code,       // Three-bit system-register selector
	output logic cond_ok,                 // Qualified condition result is valid
	output logic cond_true,               // Condition result after inversion
	output logic [10:0] sr_sel,           // One-hot register select
	output logic sr_ok,                   // Selector decode valid this cycle
	output logic sr_reserved              // Reserved selector code seen
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cond_ok;          // Condition output valid
		logic cond_true;        // Condition output
		logic [10:0] sr_sel;    // Register select
		logic sr_ok;            // Selector output valid
		logic sr_reserved;      // Reserved flag
	} csdec_state_t;

	csdec_state_t st_ff;        // Registered state
	csdec_state_t nxt_st;       // Next state
	logic raw_hit;              // Condition before inversion
	logic [10:0] sel_dec;       // Combinational select

	// ----------------------------------------------------------------
	// Condition evaluation
	// ----------------------------------------------------------------
	csdec_cond_eval csdec_cond_eval_inst
	(
		.sel(cond_field[csdec_pkg::SEL_MSB:csdec_pkg::SEL_LSB]),
		.flag_cf(flag_cf),
		.flag_zf(flag_zf),
		.flag_sf(flag_sf),
		.flag_of(flag_of),
		.flag_pf(flag_pf),
		.hit(raw_hit)
	);

	// ----------------------------------------------------------------
	// Selector decode
	// ----------------------------------------------------------------
	// Reserved codes give an all-zero select so no register is touched
	always_comb
	begin
		sel_dec = csdec_pkg::RST_SEL;
		unique case (csdec_pkg::csdec_cls_t'(sr_class))
			csdec_pkg::CSDEC_CLS_CTRL:
			begin
				if (sr_code == csdec_pkg::SR_CODE_0)
					sel_dec[csdec_pkg::B_CTRL0] = 1'b1;
				if (sr_code == csdec_pkg::SR_CODE_2)
					sel_dec[csdec_pkg::B_CTRL2] = 1'b1;
				if (sr_code == csdec_pkg::SR_CODE_3)
					sel_dec[csdec_pkg::B_CTRL3] = 1'b1;
			end
			csdec_pkg::CSDEC_CLS_DEBUG:
			begin
				if (sr_code == csdec_pkg::SR_CODE_0)
					sel_dec[csdec_pkg::B_DBG0] = 1'b1;
				if (sr_code == csdec_pkg::SR_CODE_1)
					sel_dec[csdec_pkg::B_DBG1] = 1'b1;
				if (sr_code == csdec_pkg::SR_CODE_2)
					sel_dec[csdec_pkg::B_DBG2] = 1'b1;
				if (sr_code == csdec_pkg::SR_CODE_3)
					sel_dec[csdec_pkg::B_DBG3] = 1'b1;
				if (sr_code == csdec_pkg::SR_CODE_6)
					sel_dec[csdec_pkg::B_DBG6] = 1'b1;
				if (sr_code == csdec_pkg::SR_CODE_7)
					sel_dec[csdec_pkg::B_DBG7] = 1'b1;
			end
			csdec_pkg::CSDEC_CLS_TEST:
			begin
				if (sr_code == csdec_pkg::SR_CODE_6)
					sel_dec[csdec_pkg::B_TST6] = 1'b1;
				if (sr_code == csdec_pkg::SR_CODE_7)
					sel_dec[csdec_pkg::B_TST7] = 1'b1;
			end
			csdec_pkg::CSDEC_CLS_NONE:
			begin
				sel_dec = csdec_pkg::RST_SEL;                    // Not a move
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.cond_ok = cond_valid;
		// Invert bit negates the raw condition
		nxt_st.cond_true = cond_valid & (raw_hit ^ cond_field[csdec_pkg::INV_BIT]);
		nxt_st.sr_ok = sr_valid;
		nxt_st.sr_sel = sr_valid ? sel_dec : csdec_pkg::RST_SEL;
		// Flag only; the source should never send these, but we report it
		nxt_st.sr_reserved = sr_valid && (sr_class != 2'(csdec_pkg::CSDEC_CLS_NONE))
			&& (sel_dec == csdec_pkg::RST_SEL);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			// Every field from its package reset value, nothing selected
			st_ff <= '{csdec_pkg::RST_BIT, csdec_pkg::RST_BIT, csdec_pkg::RST_SEL,
				csdec_pkg::RST_BIT, csdec_pkg::RST_BIT};
		end
		else if (ce)
		begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs straight from flops
	// ----------------------------------------------------------------
	assign cond_ok = st_ff.cond_ok;
	assign cond_true = st_ff.cond_true;
	assign sr_sel = st_ff.sr_sel;
	assign sr_ok = st_ff.sr_ok;
	assign sr_reserved = st_ff.sr_reserved;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_inv_negates: assert property (@(posedge clk) disable iff (!nrst)
		(ce && cond_valid && !raw_hit) |=> (cond_true == $past(cond_field[0])))
		else $error("Invert bit not applied");
	a_cond_below: assert property (@(posedge clk) disable iff (!nrst)
		(ce && cond_valid && cond_field == 4'h2) |=> (cond_true == $past(flag_cf)))
		else $error("Below condition wrong");
	a_cond_above: assert property (@(posedge clk) disable iff (!nrst)
		(ce && cond_valid && cond_field == 4'h7) |=> (cond_true == !$past(flag_cf | flag_zf)))
		else $error("Above condition wrong");
	a_cond_greater: assert property (@(posedge clk) disable iff (!nrst)
		(ce && cond_valid && cond_field == 4'hF)
		|=> (cond_true == !$past((flag_sf ^ flag_of) | flag_zf)))
		else $error("Greater condition wrong");
	a_cond_parodd: assert property (@(posedge clk) disable iff (!nrst)
		(ce && cond_valid && cond_field == 4'hB) |=> (cond_true == !$past(flag_pf)))
		else $error("Parity odd wrong");
	a_ctrl_one_rsv: assert property (@(posedge clk) disable iff (!nrst)
		(ce && sr_valid && sr_class == 2'h0 && sr_code == 3'h1) |=> (sr_reserved && sr_sel == '0))
		else $error("Control code one not reserved");
	a_dbg_seven: assert property (@(posedge clk) disable iff (!nrst)
		(ce && sr_valid && sr_class == 2'h1 && sr_code == 3'h7) |=> sr_sel[8] && $onehot(sr_sel))
		else $error("Debug seven not selected");
	a_test_six: assert property (@(posedge clk) disable iff (!nrst)
		(ce && sr_valid && sr_class == 2'h2 && sr_code == 3'h6) |=> sr_sel[9] && !sr_reserved)
		else $error("Test six not selected");

	// ----------------------------------------------------------------
	// Further condition checks on codes 0, 3, 4, 5, 8, A and C, plus the invert bit on a true condition
	// ----------------------------------------------------------------
	// The true-condition case catches an inversion stuck at pass-through
	a_inv_keeps: assert property (@(posedge clk) disable iff (!nrst)
		(ce && cond_valid && raw_hit) |=> (cond_true == !$past(cond_field[0])))
		else $error("Invert bit wrong on true condition");
	a_cond_ovfl: assert property (@(posedge clk) disable iff (!nrst)
		(ce && cond_valid && cond_field == 4'h0) |=> (cond_true == $past(flag_of)))
		else $error("Overflow condition wrong");
	a_cond_notbelow: assert property (@(posedge clk) disable iff (!nrst)
		(ce && cond_valid && cond_field == 4'h3) |=> (cond_true == !$past(flag_cf)))
		else $error("Not below condition wrong");
	a_cond_zero: assert property (@(posedge clk) disable iff (!nrst)
		(ce && cond_valid && cond_field == 4'h4) |=> (cond_true == $past(flag_zf)))
		else $error("Zero condition wrong");
	a_cond_nonzero: assert property (@(posedge clk) disable iff (!nrst)
		(ce && cond_valid && cond_field == 4'h5) |=> (cond_true == !$past(flag_zf)))
		else $error("Not zero condition wrong");
	a_cond_less: assert property (@(posedge clk) disable iff (!nrst)
		(ce && cond_valid && cond_field == 4'hC) |=> (cond_true == $past(flag_sf ^ flag_of)))
		else $error("Less condition wrong");
	a_cond_sign: assert property (@(posedge clk) disable iff (!nrst)
		(ce && cond_valid && cond_field == 4'h8) |=> (cond_true == $past(flag_sf)))
		else $error("Sign condition wrong");
	a_cond_pareven: assert property (@(posedge clk) disable iff (!nrst)
		(ce && cond_valid && cond_field == 4'hA) |=> (cond_true == $past(flag_pf)))
		else $error("Parity even wrong");
	// No field present: both condition outputs must read low
	a_cond_idle: assert property (@(posedge clk) disable iff (!nrst)
		(ce && !cond_valid) |=> (!cond_true && !cond_ok))
		else $error("Idle condition not low");

	// ----------------------------------------------------------------
	// Further selector checks, listed and reserved codes per class
	// ----------------------------------------------------------------
	a_ctrl_zero: assert property (@(posedge clk) disable iff (!nrst)
		(ce && sr_valid && sr_class == 2'h0 && sr_code == 3'h0) |=> (sr_sel == 11'h001))
		else $error("Control zero not selected");
	a_ctrl_upper: assert property (@(posedge clk) disable iff (!nrst)
		(ce && sr_valid && sr_class == 2'h0 && sr_code[2:1] == 2'b01)
		|=> (sr_sel == (11'h002 << $past(sr_code[0])) && !sr_reserved))
		else $error("Control two or three not selected");
	a_dbg_low: assert property (@(posedge clk) disable iff (!nrst)
		(ce && sr_valid && sr_class == 2'h1 && !sr_code[2])
		|=> (sr_sel == (11'h008 << $past(sr_code[1:0])) && !sr_reserved))
		else $error("Debug zero to three not selected");
	a_dbg_rsv: assert property (@(posedge clk) disable iff (!nrst)
		(ce && sr_valid && sr_class == 2'h1 && sr_code[2:1] == 2'b10)
		|=> (sr_reserved && sr_sel == 11'h000))
		else $error("Debug gap code not reserved");
	a_test_seven: assert property (@(posedge clk) disable iff (!nrst)
		(ce && sr_valid && sr_class == 2'h2 && sr_code == 3'h7) |=> (sr_sel == 11'h400))
		else $error("Test seven not selected");
	a_test_rsv: assert property (@(posedge clk) disable iff (!nrst)
		(ce && sr_valid && sr_class == 2'h2 && sr_code[2:1] != 2'b11)
		|=> (sr_reserved && sr_sel == 11'h000))
		else $error("Test low code not reserved");
	// Class three is not a move, so nothing is selected or flagged
	a_none_quiet: assert property (@(posedge clk) disable iff (!nrst)
		(ce && sr_valid && sr_class == 2'h3) |=> (sr_ok && sr_sel == 11'h000 && !sr_reserved))
		else $error("Non-move class selected a register");
	// Enable low must freeze every registered output
	a_hold_frozen: assert property (@(posedge clk) disable iff (!nrst)
		!ce |=> $stable({cond_ok, cond_true, sr_sel, sr_ok, sr_reserved}))
		else $error("Outputs moved while enable low");

endmodule : csdec_top

// ### tb/csdec_fetch_model.sv
// Purpose: Instruction stream model that feeds the selector field of the decoder
// Assumes: The bench picks a raw class and code each cycle
// Notes: Unlisted codes reach the decoder only while allow_rsvd is high
module csdec_fetch_model
(
	input wire logic allow_rsvd,       // Scenario permits reserved codes
	input wire logic [1:0] raw_class,  // Class chosen by the bench
	input wire logic [2:0] raw_code,   // Code chosen by the bench
	output logic [1:0] sr_class,       // Class presented to the decoder
	output logic [2:0] sr_code         // Code presented to the decoder
);
	timeunit 1ns;
	timeprecision 1ps;
	logic legal;  // Code is listed for its class
	// ----------------------------------------------------------------
	// Listed codes per class; class 3 carries no selector at all
	// ----------------------------------------------------------------
	always_comb
	begin
		case (raw_class)
			2'h0: legal = (raw_code == 3'h0) || (raw_code == 3'h2) || (raw_code == 3'h3);
			2'h1: legal = (raw_code != 3'h4) && (raw_code != 3'h5);
			2'h2: legal = raw_code[2] & raw_code[1];
			default: legal = 1'b1;
		endcase
	end
	// A real stream never issues a reserved code, so swap in the lowest listed one
	assign sr_class = raw_class;
	assign sr_code = (legal || allow_rsvd) ? raw_code : {raw_class[1], raw_class[1], 1'b0};
endmodule : csdec_fetch_model

// ### tb/csdec_top_test.sv
// Purpose: Self-checking bench for the condition and selector field decoder
// Assumes: Outputs follow one enabled edge after inputs, per the hand-over
// Notes: Driver queues expectations; a watcher pops one per enabled edge
module csdec_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, nrst = 1'b0, ce = 1'b0, cond_valid = 1'b0, sr_valid = 1'b0;
	logic allow_rsvd = 1'b0;            // Lets the stream model pass reserved codes
	logic [3:0] cond_field = 4'h0;      // Conditional-test field
	logic [4:0] flags = 5'h00;          // Order: carry, zero, sign, overflow, parity
	logic [1:0] raw_class = 2'h3;       // Raw class handed to the stream model
	logic [2:0] raw_code = 3'h0;        // Raw code handed to the stream model
	logic [1:0] sr_class;               // Class as the model presents it
	logic [2:0] sr_code;                // Code as the model presents it
	logic cond_ok, cond_true, sr_ok, sr_reserved;
	logic [10:0] sr_sel;                // One-hot register select
	logic [14:0] held = 15'h0000;       // Expected outputs; zero until first enabled edge
	logic [14:0] seen;                  // Outputs gathered for comparison
	logic en;                           // Clock enable sampled at the edge
	logic [14:0] expq[$];               // Expected results, oldest first
	logic [31:0] seed = 32'hF2DE0FAD;   // Fixed seed keeps runs repeatable
	logic [31:0] r;                     // Current random word
	int mismatches = 0;
	int checks = 0;
	// Free-running 40 MHz core clock
	always #12.5 clk = ~clk;
	csdec_top csdec_top_inst (.clk(clk), .nrst(nrst), .ce(ce), .cond_valid(cond_valid),
		.cond_field(cond_field), .flag_cf(flags[4]), .flag_zf(flags[3]), .flag_sf(flags[2]),
		.flag_of(flags[1]), .flag_pf(flags[0]), .sr_valid(sr_valid), .sr_class(sr_class),
		.sr_code(sr_code), .cond_ok(cond_ok), .cond_true(cond_true), .sr_sel(sr_sel),
		.sr_ok(sr_ok), .sr_reserved(sr_reserved));
	csdec_fetch_model csdec_fetch_model_inst (.allow_rsvd(allow_rsvd), .raw_class(raw_class),
		.raw_code(raw_code), .sr_class(sr_class), .sr_code(sr_code));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Reference decode from the field tables, worked out independently
	function logic [14:0] expect_now();
		logic hit;
		logic rsv;
		logic [10:0] one;
		case (cond_field[3:1])
			3'h0: hit = flags[1];
			3'h1: hit = flags[4];
			3'h2: hit = flags[3];
			3'h3: hit = flags[4] | flags[3];
			3'h4: hit = flags[2];
			3'h5: hit = flags[0];
			3'h6: hit = flags[2] ^ flags[1];
			default: hit = (flags[2] ^ flags[1]) | flags[3];
		endcase
		hit = cond_valid & (hit ^ cond_field[0]);
		one = 11'h000;
		rsv = 1'b0;
		if (sr_valid && sr_class == 2'h0)
			case (sr_code)
				3'h0: one[0] = 1'b1;
				3'h2: one[1] = 1'b1;
				3'h3: one[2] = 1'b1;
				default: rsv = 1'b1;
			endcase
		else if (sr_valid && sr_class == 2'h1)
			if (sr_code[2:1] == 2'b10) rsv = 1'b1;
			else if (!sr_code[2]) one[3 + sr_code] = 1'b1;
			else one[sr_code + 1] = 1'b1;
		else if (sr_valid && sr_class == 2'h2)
			if (sr_code[2:1] == 2'b11) one[sr_code + 3] = 1'b1;
			else rsv = 1'b1;
		return {cond_valid, hit, sr_valid, rsv, one};
	endfunction : expect_now
	task check(input logic [12:0] got, input logic [12:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// One cycle of stimulus on the falling edge; the note is queued only if enabled
	task drive(input logic cv, input logic [3:0] cf, input logic [4:0] fl, input logic sv,
		input logic [1:0] cl, input logic [2:0] cd, input logic e, input logic rs);
		@(negedge clk);
		{cond_valid, cond_field, flags, sr_valid, raw_class, raw_code} = {cv, cf, fl, sv, cl, cd};
		ce = e;
		allow_rsvd = rs;
		#1;
		if (e) expq.push_back(expect_now());
	endtask : drive
	task close_out();
		$display("counts: checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out
	// ----------------------------------------------------------------
	// Watcher: outputs must hold between enabled edges, so compare every edge
	// ----------------------------------------------------------------
	always @(posedge clk)
	begin
		en = ce;
		#1;
		if (nrst)
		begin
			if (en) held = expq.pop_front();
			seen = {cond_ok, cond_true, sr_ok, sr_reserved, sr_sel};
			check({11'h000, seen[14:13]}, {11'h000, held[14:13]});
			check(seen[12:0], held[12:0]);
		end
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		@(negedge clk) nrst = 1'b1;
		// Every condition code against every flag pattern, back to back
		for (int i = 0; i < 512; i++) drive(1'b1, i[3:0], i[8:4], 1'b0, 2'h3, 3'h0, 1'b1, 1'b0);
		$display("test cond_codes done");
		// Every class and code, reserved ones included, valid and idle
		for (int i = 0; i < 64; i++) drive(1'b0, 4'h0, 5'h00, i[5], i[4:3], i[2:0], 1'b1, 1'b1);
		$display("test selector_codes done");
		// Random mix with clock-enable gaps; stream withholds reserved codes mostly
		for (int i = 0; i < 400; i++)
		begin
			r = rnd();
			drive(r[0], r[4:1], r[9:5], r[10], r[12:11], r[15:13], r[16] | r[17], r[18] & r[19]);
		end
		drive(1'b0, 4'h0, 5'h00, 1'b0, 2'h3, 3'h0, 1'b0, 1'b0);
		repeat (2) @(negedge clk);
		$display("test random_mix done");
		close_out();
	end
	// Watchdog well beyond the roughly 1000 cycles the scenarios take
	initial
	begin
		repeat (3000) @(posedge clk);
		mismatches++;
		close_out();
	end
endmodule : csdec_top_test
